// ---- hw/pap_cfg.svh ----
`ifndef PAP_CFG_SVH
`define PAP_CFG_SVH
// Register byte offsets
`define PAP_OFF_OUT      12'h000
`define PAP_OFF_PIN      12'h004
`define PAP_OFF_MODE     12'h008
// Mode register field positions
`define PAP_MODE_IIC     0
`define PAP_MODE_KBD_LO  1
`define PAP_MODE_KBD_HI  6
`define PAP_MODE_SWSTBY  7
// Reset values
`define PAP_RST_OUT      8'h00
`define PAP_RST_DIR      8'h00
`define PAP_RST_KBD      6'h00
`endif

// ---- hw/pap_pkg.sv ----
package pap_pkg;
    typedef logic [7:0] pap_byte_t;
    typedef logic [1:0] pap_sync_t;
endpackage

// ---- hw/pap_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pap_cfg.svh"
// Three-stage pin synchroniser; level accepted once stages two and three agree
module pap_pin_sync
    import pap_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and result
    input  wire logic pin_in,
    output logic      pin_sync
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } pap_sync_s;

    pap_sync_s st_r;
    pap_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_sync = st_r.lvl;
endmodule
`default_nettype wire

// ---- hw/pap_port.sv ----
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pap_cfg.svh"
// Contract
// - Pins 1 and 0: direction bit 0 input, 1 output driving output data.
// - Key-sense inputs of pins 1 and 0 always follow the pin.
// - One independently controlled input pull-up per port pin.
// - I2C pin-select set forces pull-ups of pins 7 to 4 off.
// - Keyboard function selected on pins 7 to 2 forces that pull-up off.
// - All pull-ups off during reset and hardware standby.
// - Otherwise pull-up on only when direction 0 and output data 1.
// - Output data register readable and writable regardless of direction.
// - Pin-state address reads live pins, writes set direction bits.
// - Keyboard enable on pins 7 to 2 hands them to keyboard buffer.
module pap_port
    import pap_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Standby
    input  wire logic        hw_standby,
    // Pins
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    output logic      [7:0]  pullup_en,
    // Keyboard buffer side of pins 7 to 2, key sense of pins 1 and 0
    input  wire logic [5:0]  kbd_out,
    input  wire logic [5:0]  kbd_oe,
    output logic      [1:0]  key_sense_input
);
    typedef struct packed {
        pap_byte_t   out;
        pap_byte_t   dir;
        logic [5:0]  kbd_en;
        logic        iic;
        logic        swstby;
        logic [31:0] rdata;
    } pap_state_s;

    pap_state_s st_r;
    pap_state_s st_nxt;
    pap_byte_t  pin_lvl;
    logic       wr;
    logic       rd;
    logic       hit;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_sync
            pap_pin_sync u_sync (
                .pclk     (pclk),
                .presetn  (presetn),
                .pin_in   (pin_in[g]),
                .pin_sync (pin_lvl[g])
            );
        end
    endgenerate

    // Zero-wait slave; byte lane 0 holds all fields
    assign hit = (paddr == `PAP_OFF_OUT) || (paddr == `PAP_OFF_PIN)
                 || (paddr == `PAP_OFF_MODE);
    assign wr  = psel && penable && pwrite && hit && pstrb[0];
    assign rd  = psel && !penable && !pwrite;

    always_comb begin
        st_nxt = st_r;
        if (wr) begin
            unique case (paddr)
                `PAP_OFF_OUT: st_nxt.out = pwdata[7:0];
                `PAP_OFF_PIN: st_nxt.dir = pwdata[7:0];
                default: begin
                    st_nxt.iic    = pwdata[`PAP_MODE_IIC];
                    st_nxt.kbd_en = pwdata[`PAP_MODE_KBD_HI:`PAP_MODE_KBD_LO];
                    st_nxt.swstby = pwdata[`PAP_MODE_SWSTBY];
                end
            endcase
        end
        // Read data captured in setup so it comes from a flip-flop
        if (rd) begin
            st_nxt.rdata = 32'h0000_0000;
            if (paddr == `PAP_OFF_OUT) begin
                st_nxt.rdata[7:0] = st_r.out;
            end else if (paddr == `PAP_OFF_PIN) begin
                st_nxt.rdata[7:0] = pin_lvl;
            end else if (paddr == `PAP_OFF_MODE) begin
                st_nxt.rdata[`PAP_MODE_IIC] = st_r.iic;
                st_nxt.rdata[`PAP_MODE_KBD_HI:`PAP_MODE_KBD_LO] = st_r.kbd_en;
                st_nxt.rdata[`PAP_MODE_SWSTBY] = st_r.swstby;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r        <= '0;
            st_r.out    <= `PAP_RST_OUT;
            st_r.dir    <= `PAP_RST_DIR;
            st_r.kbd_en <= `PAP_RST_KBD;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata  = st_r.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Pin drive
    always_comb begin
        pin_out = st_r.out;
        pin_oe  = st_r.dir;
        for (int i = 0; i < 6; i++) begin
            if (st_r.kbd_en[i]) begin
                pin_out[i+2] = kbd_out[i];
                pin_oe[i+2]  = kbd_oe[i];
            end
        end
    end

    // Key sense always follows the pin, whatever the direction
    assign key_sense_input = pin_lvl[1:0];

    // Pull-ups: purely combinational so mode changes act at once
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pullup_en[i] = !st_r.dir[i] && st_r.out[i];
        end
        if (st_r.iic) begin
            pullup_en[7:4] = 4'h0;
        end
        pullup_en[7:2] = pullup_en[7:2] & ~st_r.kbd_en;
        if (!presetn || hw_standby) begin
            pullup_en = 8'h00;
        end
    end

    AST_PU_IIC: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r.iic |-> pullup_en[7:4] == 4'h0
    ) else $error("iic pull-up on");

    AST_PU_KBD: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pullup_en[7:2] & st_r.kbd_en) == 6'h00
    ) else $error("kbd pull-up on");

    AST_PU_STBY: assert property (
        @(posedge pclk) disable iff (!presetn)
        hw_standby |-> pullup_en == 8'h00
    ) else $error("standby pull-up");

    AST_PU_ON: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!hw_standby && !st_r.iic && st_r.kbd_en == 6'h00)
        |-> pullup_en == (~st_r.dir & st_r.out)
    ) else $error("pull-up wrong");

    AST_DIR_WR: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `PAP_OFF_PIN) |=> st_r.dir == $past(pwdata[7:0])
    ) else $error("dir write lost");

    AST_OUT_WR: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `PAP_OFF_OUT) |=> st_r.out == $past(pwdata[7:0])
    ) else $error("out write lost");

    AST_OE_LO: assert property (
        @(posedge pclk) disable iff (!presetn)
        pin_oe[1:0] == st_r.dir[1:0] && pin_out[1:0] == st_r.out[1:0]
    ) else $error("low pin drive");

    AST_KEY: assert property (
        @(posedge pclk) disable iff (!presetn)
        key_sense_input == pin_lvl[1:0]
    ) else $error("key sense");

    AST_KBD_OE: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r.kbd_en[0] |-> pin_oe[2] == kbd_oe[0]
    ) else $error("kbd drive");

    // Reset must hold pull-ups off even before the first clock
    AST_RST_PU: assert property (
        @(posedge pclk)
        !presetn |-> pullup_en == 8'h00
    ) else $error("pull-up on in reset");

    AST_RST_OE: assert property (
        @(posedge pclk)
        !presetn |-> pin_oe == 8'h00
    ) else $error("pin driven in reset");

    AST_PU_DIR_OUT: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pullup_en & (st_r.dir | ~st_r.out)) == 8'h00
    ) else $error("pull-up on output pin");

    AST_PU_SWSTBY: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.swstby && !hw_standby && !st_r.iic && st_r.kbd_en == 6'h00)
        |-> pullup_en == (~st_r.dir & st_r.out)
    ) else $error("soft standby pull-up");

    AST_PU_LO_NIBBLE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!hw_standby && st_r.kbd_en[1:0] == 2'h0)
        |-> pullup_en[3:0] == (~st_r.dir[3:0] & st_r.out[3:0])
    ) else $error("low nibble pull-up");

    AST_PU_LOW2: assert property (
        @(posedge pclk) disable iff (!presetn)
        !hw_standby |-> pullup_en[1:0] == (~st_r.dir[1:0] & st_r.out[1:0])
    ) else $error("pins 1 0 pull-up");

    AST_KBD_OE_ALL: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((pin_oe[7:2] ^ kbd_oe) & st_r.kbd_en) == 6'h00
    ) else $error("kbd enable drive");

    AST_KBD_OUT_ALL: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((pin_out[7:2] ^ kbd_out) & st_r.kbd_en) == 6'h00
    ) else $error("kbd data drive");

    AST_PLAIN_OE: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((pin_oe[7:2] ^ st_r.dir[7:2]) & ~st_r.kbd_en) == 6'h00
    ) else $error("plain pin direction");

    AST_PLAIN_OUT: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((pin_out[7:2] ^ st_r.out[7:2]) & ~st_r.kbd_en) == 6'h00
    ) else $error("plain pin data");

    AST_RD_OUT: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == `PAP_OFF_OUT) |=> prdata == {24'h000000, $past(st_r.out)}
    ) else $error("output data read");

    AST_RD_PIN: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == `PAP_OFF_PIN) |=> prdata == {24'h000000, $past(pin_lvl)}
    ) else $error("pin state read");

    AST_RD_UNMAPPED: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd && !hit) |=> prdata == 32'h0000_0000
    ) else $error("unmapped read data");

    AST_OUT_HOLD: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(wr && paddr == `PAP_OFF_OUT) |=> $stable(st_r.out)
    ) else $error("output data moved");

    AST_DIR_HOLD: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(wr && paddr == `PAP_OFF_PIN) |=> $stable(st_r.dir)
    ) else $error("direction moved");

    // Lane 0 carries every field, so a write without it is dropped
    AST_STRB_IGN: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && !pstrb[0])
        |=> $stable(st_r.out) && $stable(st_r.dir)
    ) else $error("strobe-less write landed");

    AST_PREADY: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready
    ) else $error("wait state inserted");

    AST_SLVERR_OK: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && hit) |-> !pslverr
    ) else $error("error on mapped access");

    AST_SLVERR_BAD: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !hit) |-> pslverr
    ) else $error("no error on unmapped access");

    AST_KEY_OUTDIR: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.dir[1:0] != 2'h0) |-> key_sense_input == pin_lvl[1:0]
    ) else $error("key sense lost on output");

    AST_MODE_IIC_WR: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `PAP_OFF_MODE) |=> st_r.iic == $past(pwdata[`PAP_MODE_IIC])
    ) else $error("iic select write lost");

    AST_MODE_KBD_WR: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `PAP_OFF_MODE) |=> st_r.kbd_en == $past(pwdata[6:1])
    ) else $error("kbd enable write lost");
endmodule
`default_nettype wire

// ---- verification/tb_port_a_pin_pullup_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pap_cfg.svh"
module tb_port_a_pin_pullup_control;
    import pap_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, hw_standby, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    pap_byte_t   pin_in, pin_out, pin_oe, pullup_en;
    logic [5:0]  kbd_out, kbd_oe;
    logic [1:0]  key_sense_input;
    int          fails, tests_run;
    // Packed as output, direction, mode, standby
    logic [24:0] tbl [8] = '{{8'hff, 8'h00, 8'h00, 1'b0}, {8'hff, 8'h0f, 8'h00, 1'b0},
        {8'ha5, 8'h00, 8'h00, 1'b0}, {8'hff, 8'h00, 8'h01, 1'b0}, {8'hff, 8'h00, 8'h7e, 1'b0},
        {8'hff, 8'h30, 8'h2b, 1'b0}, {8'hff, 8'h00, 8'h80, 1'b0}, {8'hff, 8'h00, 8'h00, 1'b1}};
    pap_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hw_standby(hw_standby), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .kbd_out(kbd_out),
        .kbd_oe(kbd_oe), .key_sense_input(key_sense_input));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Never assumes the zero-wait answer; the bound only cuts a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic cfg(input pap_byte_t o, input pap_byte_t d, input pap_byte_t m, input logic s);
        pap_byte_t exp;
        apb(1'b1, `PAP_OFF_OUT, {24'h0, o});
        apb(1'b1, `PAP_OFF_PIN, {24'h0, d});
        apb(1'b1, `PAP_OFF_MODE, {24'h0, m});
        hw_standby <= s;
        @(posedge pclk);
        #1;
        exp = ~d & o;
        if (m[0]) exp[7:4] = 4'h0;
        exp[7:2] = exp[7:2] & ~m[6:1];
        if (s) exp = 8'h00;
        chk(pullup_en, exp);
    endtask
    task automatic t_pull;
        foreach (tbl[i]) cfg(tbl[i][24:17], tbl[i][16:9], tbl[i][8:1], tbl[i][0]);
    endtask
    task automatic t_dir;
        cfg(8'h01, 8'h03, 8'h00, 1'b0);
        chk(pin_oe[1:0], 2'h3);
        chk(pin_out[1:0], 2'h1);
        pin_in <= 8'h96;
        repeat (6) @(posedge pclk);
        chk(key_sense_input, 2'h2);
        cfg(8'h01, 8'h00, 8'h00, 1'b0);
        chk(pin_oe[1:0], 2'h0);
        apb(1'b0, `PAP_OFF_PIN, 32'h0);
        chk(rd, 32'h96);
    endtask
    task automatic t_regs;
        cfg(8'h5a, 8'hff, 8'h00, 1'b0);
        apb(1'b0, `PAP_OFF_OUT, 32'h0);
        chk(rd, 32'h5a);
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic t_kbd;
        cfg(8'h00, 8'h00, 8'h7e, 1'b0);
        chk(pin_oe[7:2], kbd_oe);
        chk(pin_out[7:2], kbd_out);
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; pstrb = 4'hf; hw_standby = 1'b0; pin_in = 8'h00;
        kbd_out = 6'h2d; kbd_oe = 6'h33; fails = 0; tests_run = 0;
        repeat (12) @(posedge pclk);
        chk(pullup_en, 8'h00);
        chk(pin_oe, 8'h00);
        presetn <= 1'b1;
        t_pull();
        t_dir();
        t_regs();
        t_kbd();
        test_done();
    end
endmodule
`default_nettype wire
